// file: src/isa_decode_pkg.sv
// constants, opcodes, clock budgets and carrier types for the opcode decoder
// Summary of operation
// (RULE1) test reg/mem with reg: flags only, 3/10
// (RULE2) test immediate, selector sub-field 000: 4/10
// (RULE3) test accumulator immediate, size-dependent data: 3/4
// (RULE4) string move, one element in 14 clocks
// (RULE5) string port in/out 14; repeated output 8+8n
// (RULE6) string compare 22; conditional repeat 5+22n
// (RULE7) string scan 15; conditional repeat 5+15n
// (RULE8) string load 12, store 10, bit 1 distinguishes
// (RULE9) repeat prefix iterates count register; move 8+8n
// (RULE10) conditional jumps 0111cccc: 4 not taken, 13 taken
// (RULE11) remaining condition nibbles, 8-bit displacement
// (RULE12) near procedure invoke, 16-bit displacement, 15 clocks
// (RULE13) near exit 16, with stack adjust 18
// (RULE14) far exit 22, with stack adjust 25
// (RULE15) short unconditional jump, 14 clocks
// (RULE16) repeat while equal/unequal: 5 fall, 16 branch
// (RULE17) jump if count zero: 6/16
// (RULE18) overflow trap: 48 taken, 4 not
// (RULE19) range check with selector byte, 33-35 clocks
// (RULE20) carry invert, clear, set: 2 clocks
// (RULE21) bus-hold prefix 2 clocks, locks next instruction
// (RULE22) coprocessor handoff, six-bit operation, 6 clocks
// (RULE23) lowest opcode bit selects byte or word
// (RULE24) unmatched opcode reported as undefined
package isa_decode_pkg;
  localparam int budget_w = 24;
  // opcodes matched on their upper seven bits; the low bit is the size bit, or the zero test for opc_rep
  localparam logic [6:0] opc_test_rm = 7'h42;
  localparam logic [6:0] opc_test_imm = 7'h7b;
  localparam logic [6:0] opc_test_acc = 7'h54;
  localparam logic [6:0] opc_move = 7'h52;
  localparam logic [6:0] opc_in = 7'h36;
  localparam logic [6:0] opc_out = 7'h37;
  localparam logic [6:0] opc_cmp = 7'h53;
  localparam logic [6:0] opc_scan = 7'h57;
  localparam logic [6:0] opc_load = 7'h56;
  localparam logic [6:0] opc_store = 7'h55;
  localparam logic [6:0] opc_rep = 7'h79;
  // whole-byte opcodes, upper-bit patterns for jcc and esc groups, test selector sub-field
  localparam logic [3:0] opc_jcc_hi = 4'h7;
  localparam logic [4:0] opc_esc_hi = 5'h1b;
  localparam logic [7:0] opc_call = 8'he8;
  localparam logic [7:0] opc_exit_near = 8'hc3;
  localparam logic [7:0] opc_exit_near_imm = 8'hc2;
  localparam logic [7:0] opc_exit_far = 8'hcb;
  localparam logic [7:0] opc_exit_far_imm = 8'hca;
  localparam logic [7:0] opc_jmp_short = 8'heb;
  localparam logic [7:0] opc_loop_eq = 8'he1;
  localparam logic [7:0] opc_loop_ne = 8'he0;
  localparam logic [7:0] opc_loop = 8'he2;
  localparam logic [7:0] opc_jump_if_count_zero = 8'he3;
  localparam logic [7:0] opc_into = 8'hce;
  localparam logic [7:0] opc_bound = 8'h62;
  localparam logic [7:0] opc_cmc = 8'hf5;
  localparam logic [7:0] opc_clc = 8'hf8;
  localparam logic [7:0] opc_stc = 8'hf9;
  localparam logic [7:0] opc_lock = 8'hf0;
  localparam logic [2:0] test_imm_sub = 3'h0;
  // clock budgets
  localparam logic [7:0] clk_test_reg = 8'h03;
  localparam logic [7:0] clk_test_mem = 8'h0a;
  localparam logic [7:0] clk_test_imm_reg = 8'h04;
  localparam logic [7:0] clk_test_imm_mem = 8'h0a;
  localparam logic [7:0] clk_test_acc_byte = 8'h03;
  localparam logic [7:0] clk_test_acc_word = 8'h04;
  localparam logic [7:0] clk_move = 8'h0e;
  localparam logic [7:0] clk_port = 8'h0e;
  localparam logic [7:0] clk_cmp = 8'h16;
  localparam logic [7:0] clk_scan = 8'h0f;
  localparam logic [7:0] clk_load = 8'h0c;
  localparam logic [7:0] clk_store = 8'h0a;
  localparam logic [7:0] rep_setup_move = 8'h08;
  localparam logic [7:0] rep_per_move = 8'h08;
  localparam logic [7:0] rep_setup_cmp = 8'h05;
  localparam logic [7:0] rep_setup_load = 8'h06;
  localparam logic [7:0] rep_per_load = 8'h0b;
  localparam logic [7:0] rep_per_store = 8'h09;
  localparam logic [7:0] clk_jcc_not = 8'h04;
  localparam logic [7:0] clk_jcc_taken = 8'h0d;
  localparam logic [7:0] clk_call = 8'h0f;
  localparam logic [7:0] clk_exit_near = 8'h10;
  localparam logic [7:0] clk_exit_near_imm = 8'h12;
  localparam logic [7:0] clk_exit_far = 8'h16;
  localparam logic [7:0] clk_exit_far_imm = 8'h19;
  localparam logic [7:0] clk_jmp_short = 8'h0e;
  localparam logic [7:0] clk_loop_fall = 8'h05;
  localparam logic [7:0] clk_loop_count_fall = 8'h06;
  localparam logic [7:0] clk_loop_branch = 8'h10;
  localparam logic [7:0] clk_trap_taken = 8'h30;
  localparam logic [7:0] clk_trap_not = 8'h04;
  localparam logic [7:0] clk_bound_min = 8'h21;
  localparam logic [7:0] clk_carry = 8'h02;
  localparam logic [7:0] clk_lock = 8'h02;
  localparam logic [7:0] clk_esc = 8'h06;

  typedef enum logic [3:0] {
    kind_undefined, kind_test, kind_string, kind_jcc, kind_call, kind_exit, kind_jmp,
    kind_loop, kind_jump_if_count_zero, kind_trap_ovf, kind_bound, kind_carry, kind_esc
  } op_kind_t;

  typedef struct packed {
    logic carry;
    logic parity;
    logic zero;
    logic sign;
    logic overflow;
  } flags_t;

  typedef struct packed {
    op_kind_t kind;
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [31:0] operands;
    logic [2:0] operand_count;
    logic word;
    logic mem_operand;
    logic flags_only;
    logic rep;
    logic rep_z;
    logic lock;
    logic taken;
    logic [5:0] esc_op;
    logic [budget_w-1:0] clocks;
  } op_t;
endpackage

// file: src/cond_eval.sv
// branch condition evaluation from a four-bit condition nibble
module cond_eval (
  input wire logic [3:0] cond,
  input wire isa_decode_pkg::flags_t flags,
  output logic taken
);
  logic base;

  always_comb begin
    case (cond[3:1])
      3'h0: base = flags.overflow;
      3'h1: base = flags.carry;
      3'h2: base = flags.zero;
      3'h3: base = flags.carry | flags.zero;
      3'h4: base = flags.sign;
      3'h5: base = flags.parity;
      3'h6: base = flags.sign ^ flags.overflow;
      3'h7: base = (flags.sign ^ flags.overflow) | flags.zero;
      default: base = 1'b0;
    endcase
  end

  // odd nibble is the negated condition
  assign taken = base ^ cond[0]; // RULE10 RULE11
endmodule

// file: src/repeat_cost.sv
// cost of a repeated string operation: setup plus per-element times count
module repeat_cost (
  input wire logic [7:0] setup,
  input wire logic [7:0] per,
  input wire logic [15:0] count,
  output logic [isa_decode_pkg::budget_w-1:0] total
);
  logic [23:0] product;

  assign product = per * count;
  assign total = product + {16'h0000, setup}; // RULE9
endmodule

// file: src/isa_opcode_decode_timing.sv
// opcode decoder with execution clock budgets for the instruction groups
module isa_opcode_decode_timing (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  input wire isa_decode_pkg::flags_t flags,
  input wire logic [15:0] count_register,
  output logic op_valid,
  output isa_decode_pkg::op_t op,
  input wire logic op_ready,
  output logic bus_lock
);
  typedef enum logic [4:0] {
    st_opcode = 5'h01,
    st_modrm = 5'h02,
    st_operand = 5'h04,
    st_cost = 5'h08,
    st_issue = 5'h10
  } state_t;

  logic [1:0] rst_sync;
  logic rst_n;
  state_t state;
  state_t next_state;
  logic [7:0] opcode;
  logic [7:0] modrm;
  logic [31:0] operands;
  logic [2:0] got;
  logic [2:0] remain;
  logic rep;
  logic rep_z;
  logic lock;
  logic undefined;
  logic [isa_decode_pkg::budget_w-1:0] next_clocks;
  logic next_taken;

  // reset released through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // decode on the arriving byte while fetching the opcode, else on the held one
  wire in_opcode = (state == st_opcode);
  wire take = byte_valid & byte_ready;
  wire [7:0] cur = in_opcode ? byte_data : opcode;
  wire w = cur[0]; // RULE23

  wire d_test_rm = (cur[7:1] == isa_decode_pkg::opc_test_rm); // RULE1
  wire d_test_imm = (cur[7:1] == isa_decode_pkg::opc_test_imm); // RULE2
  wire d_test_acc = (cur[7:1] == isa_decode_pkg::opc_test_acc); // RULE3
  wire d_move = (cur[7:1] == isa_decode_pkg::opc_move); // RULE4
  wire d_in = (cur[7:1] == isa_decode_pkg::opc_in); // RULE5
  wire d_out = (cur[7:1] == isa_decode_pkg::opc_out); // RULE5
  wire d_cmp = (cur[7:1] == isa_decode_pkg::opc_cmp); // RULE6
  wire d_scan = (cur[7:1] == isa_decode_pkg::opc_scan); // RULE7
  wire d_load = (cur[7:1] == isa_decode_pkg::opc_load); // RULE8
  wire d_store = (cur[7:1] == isa_decode_pkg::opc_store); // RULE8
  wire d_string = d_move | d_in | d_out | d_cmp | d_scan | d_load | d_store;
  wire d_test = d_test_rm | d_test_imm | d_test_acc;
  wire d_jcc = (cur[7:4] == isa_decode_pkg::opc_jcc_hi); // RULE10 RULE11
  wire d_call = (cur == isa_decode_pkg::opc_call); // RULE12
  wire d_exit_near = (cur == isa_decode_pkg::opc_exit_near); // RULE13
  wire d_exit_near_imm = (cur == isa_decode_pkg::opc_exit_near_imm); // RULE13
  wire d_exit_far = (cur == isa_decode_pkg::opc_exit_far); // RULE14
  wire d_exit_far_imm = (cur == isa_decode_pkg::opc_exit_far_imm); // RULE14
  wire d_exit_imm = d_exit_near_imm | d_exit_far_imm;
  wire d_exit = d_exit_near | d_exit_far | d_exit_imm;
  wire d_jmp = (cur == isa_decode_pkg::opc_jmp_short); // RULE15
  wire d_loop_eq = (cur == isa_decode_pkg::opc_loop_eq); // RULE16
  wire d_loop_ne = (cur == isa_decode_pkg::opc_loop_ne); // RULE16
  wire d_loop_cnt = (cur == isa_decode_pkg::opc_loop);
  wire d_loop = d_loop_eq | d_loop_ne | d_loop_cnt;
  wire d_jump_if_count_zero = (cur == isa_decode_pkg::opc_jump_if_count_zero); // RULE17
  wire d_into = (cur == isa_decode_pkg::opc_into); // RULE18
  wire d_bound = (cur == isa_decode_pkg::opc_bound); // RULE19
  wire d_carry = (cur == isa_decode_pkg::opc_cmc) | (cur == isa_decode_pkg::opc_clc)
    | (cur == isa_decode_pkg::opc_stc); // RULE20
  wire d_esc = (cur[7:3] == isa_decode_pkg::opc_esc_hi); // RULE22
  wire d_rep = (cur[7:1] == isa_decode_pkg::opc_rep); // RULE9
  wire d_lock = (cur == isa_decode_pkg::opc_lock); // RULE21

  wire d_defined = d_test | d_string | d_jcc | d_call | d_exit | d_jmp | d_loop | d_jump_if_count_zero
    | d_into | d_bound | d_carry | d_esc;
  wire has_w = d_test | d_string;
  wire needs_modrm = d_test_rm | d_test_imm | d_bound | d_esc;

  // immediate or displacement bytes fixed by the opcode
  wire [2:0] imm_n = (d_test_acc | d_test_imm) ? (w ? 3'h2 : 3'h1) : // RULE2 RULE3
    (d_exit_imm | d_call) ? 3'h2 : // RULE12 RULE13 RULE14
    (d_jcc | d_jmp | d_loop | d_jump_if_count_zero) ? 3'h1 : 3'h0; // RULE11 RULE15 RULE16 RULE17

  // displacement bytes implied by the arriving operand-selector byte
  wire [1:0] sel_mod = byte_data[7:6];
  wire sel_direct = (sel_mod == 2'h0) & (byte_data[2:0] == 3'h6);
  wire [2:0] disp_n = (sel_mod == 2'h1) ? 3'h1 :
    ((sel_mod == 2'h2) | sel_direct) ? 3'h2 : 3'h0;
  wire [2:0] after_modrm = disp_n + imm_n;
  wire sel_bad = d_test_imm & (byte_data[5:3] != isa_decode_pkg::test_imm_sub); // RULE2

  // branch outcomes used to pick between the two budgets
  logic jcc_taken;
  cond_eval u_cond (
    .cond(opcode[3:0]),
    .flags(flags),
    .taken(jcc_taken)
  );
  wire [15:0] count_after = count_register - 16'h0001;
  wire count_live = (count_after != 16'h0000);
  wire loop_taken = count_live & (d_loop_cnt | (d_loop_eq & flags.zero)
    | (d_loop_ne & ~flags.zero)); // RULE16
  wire jump_if_count_zero_taken = (count_register == 16'h0000); // RULE17
  wire mem = (modrm[7:6] != 2'h3);

  // repeated string cost: setup plus per-element times the count register
  wire [7:0] rep_setup = (d_cmp | d_scan) ? isa_decode_pkg::rep_setup_cmp :
    (d_load | d_store) ? isa_decode_pkg::rep_setup_load :
    isa_decode_pkg::rep_setup_move; // RULE5 RULE6 RULE7 RULE9
  wire [7:0] rep_per = d_cmp ? isa_decode_pkg::clk_cmp :
    d_scan ? isa_decode_pkg::clk_scan :
    d_load ? isa_decode_pkg::rep_per_load :
    d_store ? isa_decode_pkg::rep_per_store :
    isa_decode_pkg::rep_per_move; // RULE5 RULE6 RULE7 RULE9
  logic [isa_decode_pkg::budget_w-1:0] rep_total;
  repeat_cost u_rep (
    .setup(rep_setup),
    .per(rep_per),
    .count(count_register),
    .total(rep_total)
  );

  wire [7:0] once_string = d_move ? isa_decode_pkg::clk_move : // RULE4
    (d_in | d_out) ? isa_decode_pkg::clk_port : // RULE5
    d_cmp ? isa_decode_pkg::clk_cmp : // RULE6
    d_scan ? isa_decode_pkg::clk_scan : // RULE7
    d_load ? isa_decode_pkg::clk_load : // RULE8
    isa_decode_pkg::clk_store; // RULE8

  wire [7:0] exit_clk = d_exit_near ? isa_decode_pkg::clk_exit_near : // RULE13
    d_exit_near_imm ? isa_decode_pkg::clk_exit_near_imm : // RULE13
    d_exit_far ? isa_decode_pkg::clk_exit_far : // RULE14
    isa_decode_pkg::clk_exit_far_imm; // RULE14

  // budget of the held instruction, worked out in the cost cycle
  always_comb begin
    logic [7:0] base;
    base = 8'h00;
    next_taken = 1'b0;
    next_clocks = '0;
    if (undefined) begin
      base = 8'h00; // RULE24
    end else if (d_test_rm) begin
      base = mem ? isa_decode_pkg::clk_test_mem : isa_decode_pkg::clk_test_reg; // RULE1
    end else if (d_test_imm) begin
      base = mem ? isa_decode_pkg::clk_test_imm_mem : isa_decode_pkg::clk_test_imm_reg; // RULE2
    end else if (d_test_acc) begin
      base = w ? isa_decode_pkg::clk_test_acc_word : isa_decode_pkg::clk_test_acc_byte; // RULE3
    end else if (d_string) begin
      base = once_string;
    end else if (d_jcc) begin
      next_taken = jcc_taken;
      base = jcc_taken ? isa_decode_pkg::clk_jcc_taken : isa_decode_pkg::clk_jcc_not; // RULE10
    end else if (d_call) begin
      base = isa_decode_pkg::clk_call; // RULE12
    end else if (d_exit) begin
      base = exit_clk;
    end else if (d_jmp) begin
      base = isa_decode_pkg::clk_jmp_short; // RULE15
    end else if (d_loop) begin
      next_taken = loop_taken;
      base = loop_taken ? isa_decode_pkg::clk_loop_branch :
        (d_loop_cnt ? isa_decode_pkg::clk_loop_count_fall : isa_decode_pkg::clk_loop_fall); // RULE16
    end else if (d_jump_if_count_zero) begin
      next_taken = jump_if_count_zero_taken;
      base = jump_if_count_zero_taken ? isa_decode_pkg::clk_loop_branch :
        isa_decode_pkg::clk_loop_count_fall; // RULE17
    end else if (d_into) begin
      next_taken = flags.overflow;
      base = flags.overflow ? isa_decode_pkg::clk_trap_taken : isa_decode_pkg::clk_trap_not; // RULE18
    end else if (d_bound) begin
      base = isa_decode_pkg::clk_bound_min; // RULE19
    end else if (d_carry) begin
      base = isa_decode_pkg::clk_carry; // RULE20
    end else if (d_esc) begin
      base = isa_decode_pkg::clk_esc; // RULE22
    end
    if (rep & d_string & ~undefined) begin
      next_clocks = rep_total; // RULE9
    end else begin
      next_clocks = {16'h0000, base};
    end
    if (lock) begin
      next_clocks = next_clocks + {16'h0000, isa_decode_pkg::clk_lock}; // RULE21
    end
  end

  // sequencing of opcode, selector and operand bytes
  always_comb begin
    next_state = state;
    case (state)
      st_opcode: begin
        if (take & ~d_rep & ~d_lock) begin
          if (!d_defined) begin
            next_state = st_cost; // RULE24
          end else if (needs_modrm) begin
            next_state = st_modrm;
          end else if (imm_n != 3'h0) begin
            next_state = st_operand;
          end else begin
            next_state = st_cost;
          end
        end
      end
      st_modrm: begin
        if (take) begin
          next_state = (after_modrm != 3'h0 && !sel_bad) ? st_operand : st_cost;
        end
      end
      st_operand: begin
        if (take && remain == 3'h1) begin
          next_state = st_cost;
        end
      end
      st_cost: next_state = st_issue;
      st_issue: begin
        if (op_ready) begin
          next_state = st_opcode;
        end
      end
      default: next_state = st_opcode;
    endcase
  end

  assign byte_ready = (state == st_opcode) | (state == st_modrm) | (state == st_operand);
  assign op_valid = (state == st_issue);
  assign bus_lock = lock; // RULE21

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_opcode;
    end else begin
      state <= next_state;
    end
  end

  // prefixes and the held instruction bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rep <= 1'b0;
      rep_z <= 1'b0;
      lock <= 1'b0;
      opcode <= 8'h00;
      undefined <= 1'b0;
    end else if (state == st_issue && op_ready) begin
      rep <= 1'b0;
      rep_z <= 1'b0;
      lock <= 1'b0;
    end else if (in_opcode && take) begin
      if (d_rep) begin
        rep <= 1'b1; // RULE9
        rep_z <= byte_data[0]; // RULE6 RULE7
      end else if (d_lock) begin
        lock <= 1'b1; // RULE21
      end else begin
        opcode <= byte_data;
        undefined <= ~d_defined; // RULE24
      end
    end else if (state == st_modrm && take && sel_bad) begin
      undefined <= 1'b1; // RULE24
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modrm <= 8'h00;
      operands <= 32'h0000_0000;
      got <= 3'h0;
      remain <= 3'h0;
    end else if (in_opcode && take) begin
      modrm <= 8'h00;
      operands <= 32'h0000_0000;
      got <= 3'h0;
      remain <= imm_n;
    end else if (state == st_modrm && take) begin
      modrm <= byte_data;
      remain <= after_modrm;
    end else if (state == st_operand && take) begin
      operands[{got[1:0], 3'h0} +: 8] <= byte_data;
      got <= got + 3'h1;
      remain <= remain - 3'h1;
    end
  end

  // decoded operation, held stable while offered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op <= '0;
    end else if (state == st_cost) begin
      op.kind <= undefined ? isa_decode_pkg::kind_undefined :
        d_test ? isa_decode_pkg::kind_test :
        d_string ? isa_decode_pkg::kind_string :
        d_jcc ? isa_decode_pkg::kind_jcc :
        d_call ? isa_decode_pkg::kind_call :
        d_exit ? isa_decode_pkg::kind_exit :
        d_jmp ? isa_decode_pkg::kind_jmp :
        d_loop ? isa_decode_pkg::kind_loop :
        d_jump_if_count_zero ? isa_decode_pkg::kind_jump_if_count_zero :
        d_into ? isa_decode_pkg::kind_trap_ovf :
        d_bound ? isa_decode_pkg::kind_bound :
        d_carry ? isa_decode_pkg::kind_carry :
        isa_decode_pkg::kind_esc; // RULE24
      op.opcode <= opcode;
      op.modrm <= modrm;
      op.operands <= operands;
      op.operand_count <= got;
      op.word <= has_w & w; // RULE23
      op.mem_operand <= needs_modrm & mem;
      op.flags_only <= d_test; // RULE1
      op.rep <= rep & d_string;
      op.rep_z <= rep_z & d_string;
      op.lock <= lock;
      op.taken <= next_taken;
      op.esc_op <= d_esc ? {opcode[2:0], modrm[5:3]} : 6'h00; // RULE22
      op.clocks <= next_clocks;
    end
  end
endmodule

// file: sim/isa_opcode_decode_timing_props.sv
// concurrent checks on the opcode decoder ports
module isa_decode_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic byte_ready,
  input wire isa_decode_pkg::flags_t flags,
  input wire logic [15:0] count_register,
  input wire logic op_valid,
  input wire isa_decode_pkg::op_t op,
  input wire logic op_ready,
  input wire logic bus_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [isa_decode_pkg::budget_w-1:0] lk;
  assign lk = op.lock ? 24'h2 : 24'h0;

  chk_op_hold: assert property (op_valid && !op_ready |=> op_valid && $stable(op))
    else $error("op changed before acceptance");
  chk_issue_gap: assert property ($rose(op_valid) && op.kind != isa_decode_pkg::kind_undefined
    |-> $past(byte_valid && byte_ready, 2) && !$past(byte_ready))
    else $error("op issued at wrong distance from last byte");
  chk_fetch_held: assert property (op_valid |-> !byte_ready)
    else $error("byte accepted while op pending");
  chk_lock_set: assert property (byte_valid && byte_ready && byte_data == 8'hf0 |=> bus_lock)
    else $error("lock prefix did not raise bus lock");
  chk_lock_span: assert property (op_valid |-> op.lock == bus_lock)
    else $error("bus lock and op lock disagree");
  chk_lock_drop: assert property (op_valid && op_ready |=> !bus_lock && !op_valid)
    else $error("bus lock held past accepted op");
  chk_jcc_cost: assert property (op_valid && op.kind == isa_decode_pkg::kind_jcc
    |-> op.clocks == (op.taken ? 24'hd : 24'h4) + lk)
    else $error("conditional jump budget wrong");
  chk_carry_cost: assert property (op_valid && op.opcode inside {8'hf5, 8'hf8, 8'hf9}
    |-> op.kind == isa_decode_pkg::kind_carry && op.clocks == 24'h2 + lk)
    else $error("carry op budget wrong");
  chk_esc_field: assert property (op_valid && op.kind == isa_decode_pkg::kind_esc
    |-> op.esc_op == {op.opcode[2:0], op.modrm[5:3]} && op.clocks == 24'h6 + lk)
    else $error("coprocessor handoff decode wrong");
  chk_undef_cost: assert property (op_valid && op.kind == isa_decode_pkg::kind_undefined
    |-> op.clocks == lk)
    else $error("undefined op budget wrong");
  chk_word_bit: assert property (op_valid && op.kind == isa_decode_pkg::kind_string
    |-> op.word == op.opcode[0])
    else $error("size bit not taken from opcode");
  cov_jcc_taken: cover property (op_valid && op.kind == isa_decode_pkg::kind_jcc && op.taken);
  cov_rep: cover property (op_valid && op.rep);
  cov_lock: cover property (op_valid && bus_lock);
  cov_stall: cover property (op_valid && !op_ready);
endmodule

bind isa_opcode_decode_timing isa_decode_checker u_chk (.clk(clk), .reset_n(reset_n),
  .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready), .flags(flags),
  .count_register(count_register), .op_valid(op_valid), .op(op), .op_ready(op_ready),
  .bus_lock(bus_lock));

// file: sim/fetch_exec_model.sv
// prefetch queue feeding bytes and execution unit taking ops, optionally stalling
module fetch_exec_model (
  input wire logic clk,
  input wire logic byte_ready,
  input wire logic op_valid,
  input wire isa_decode_pkg::op_t op,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic op_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  bit slow = 0;
  isa_decode_pkg::op_t got;
  int n_got = 0;
  initial begin
    byte_valid = 0;
    byte_data = 8'h00;
    op_ready = 0;
  end
  always @(posedge clk) begin
    bit v;
    // an offered byte is held until taken; gaps show a toggling data line
    if (!byte_valid || byte_ready) begin
      if (byte_valid) void'(q.pop_front());
      v = q.size() > 0 && !(slow && $urandom % 2);
      byte_valid <= v;
      byte_data <= v ? q[0] : ~byte_data;
    end
    if (op_valid && op_ready) begin
      got <= op;
      n_got <= n_got + 1;
    end
    op_ready <= !(slow && $urandom % 2);
  end
endmodule

// file: sim/isa_opcode_decode_timing_tb.sv
// self-checking bench for the opcode decoder
module isa_opcode_decode_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] bq_t[$];
  logic clk = 0;
  logic reset_n = 0;
  isa_decode_pkg::flags_t flags = '0;
  logic [15:0] count_register = 16'h0;
  logic byte_valid, byte_ready, op_valid, op_ready, bus_lock;
  logic [7:0] byte_data;
  isa_decode_pkg::op_t op;
  int miscompares = 0;
  int n_tests = 0;
  logic [7:0] so[8] = '{8'ha4, 8'ha5, 8'h6c, 8'h6f, 8'ha6, 8'hae, 8'hac, 8'haa};
  int sc[8] = '{14, 14, 14, 14, 22, 15, 12, 10};
  logic [7:0] fo[5] = '{8'he0, 8'he1, 8'he2, 8'he3, 8'hce};
  logic [6:0] ro[5] = '{7'h53, 7'h57, 7'h52, 7'h37, 7'h36};

  initial begin
    forever #5 clk = ~clk;
  end

  isa_opcode_decode_timing dut (.clk(clk), .reset_n(reset_n), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready), .flags(flags),
    .count_register(count_register), .op_valid(op_valid), .op(op), .op_ready(op_ready),
    .bus_lock(bus_lock));
  fetch_exec_model m (.clk(clk), .byte_ready(byte_ready), .op_valid(op_valid), .op(op),
    .byte_valid(byte_valid), .byte_data(byte_data), .op_ready(op_ready));

  task automatic end_of_test();
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic issue(bq_t b);
    int n0;
    n0 = m.n_got;
    foreach (b[i]) m.q.push_back(b[i]);
    for (int i = 0; i < 300 && m.n_got == n0; i++) @(negedge clk);
    if (m.n_got == n0) begin
      miscompares++;
      end_of_test();
    end
  endtask

  task automatic t(bq_t b, isa_decode_pkg::op_kind_t k, int c);
    issue(b);
    chk("kind", 32'(k), 32'(m.got.kind));
    chk("clocks", 32'(c), 32'(m.got.clocks));
  endtask

  task automatic setfc(logic [4:0] f, logic [15:0] c);
    @(posedge clk);
    flags <= f;
    count_register <= c;
    @(negedge clk);
  endtask

  function automatic logic jt(logic [3:0] c, isa_decode_pkg::flags_t f);
    logic r;
    case (c[3:1])
      3'h0: r = f.overflow;
      3'h1: r = f.carry;
      3'h2: r = f.zero;
      3'h3: r = f.carry | f.zero;
      3'h4: r = f.sign;
      3'h5: r = f.parity;
      3'h6: r = f.sign ^ f.overflow;
      default: r = (f.sign ^ f.overflow) | f.zero;
    endcase
    return r ^ c[0];
  endfunction

  function automatic int fcost(logic [7:0] o, isa_decode_pkg::flags_t f, logic [15:0] cx);
    case (o)
      8'he0: return (cx != 16'h1 && !f.zero) ? 16 : 5;
      8'he1: return (cx != 16'h1 && f.zero) ? 16 : 5;
      8'he2: return cx != 16'h1 ? 16 : 6;
      8'he3: return cx == 16'h0 ? 16 : 6;
      8'hce: return f.overflow ? 48 : 4;
      default: return jt(o[3:0], f) ? 13 : 4;
    endcase
  endfunction

  function automatic int rcost(logic [6:0] o, int n);
    case (o)
      7'h53: return 5 + 22 * n;
      7'h57: return 5 + 15 * n;
      default: return 8 + 8 * n;
    endcase
  endfunction

  initial begin
    logic [7:0] o;
    logic [7:0] p;
    logic [15:0] cx;
    logic [4:0] f;
    int r;
    r = $urandom(89);
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(negedge clk);
    t('{8'h84, 8'hc0}, isa_decode_pkg::kind_test, 3);
    t('{8'h85, 8'h06, 8'h34, 8'h12}, isa_decode_pkg::kind_test, 10);
    chk("mem_operand", 32'h1, 32'(m.got.mem_operand));
    chk("flags_only", 32'h1, 32'(m.got.flags_only));
    t('{8'hf6, 8'hc0, 8'h55}, isa_decode_pkg::kind_test, 4);
    t('{8'hf7, 8'h46, 8'h10, 8'h34, 8'h12}, isa_decode_pkg::kind_test, 10);
    t('{8'ha8, 8'h55}, isa_decode_pkg::kind_test, 3);
    t('{8'ha9, 8'h34, 8'h12}, isa_decode_pkg::kind_test, 4);
    t('{8'hf6, 8'hc8}, isa_decode_pkg::kind_undefined, 0);
    t('{8'h0f}, isa_decode_pkg::kind_undefined, 0);
    foreach (so[i]) t('{so[i]}, isa_decode_pkg::kind_string, sc[i]);
    t('{8'he8, 8'h34, 8'h12}, isa_decode_pkg::kind_call, 15);
    chk("operands", 32'h1234, m.got.operands);
    t('{8'hc3}, isa_decode_pkg::kind_exit, 16);
    t('{8'hc2, 8'h04, 8'h00}, isa_decode_pkg::kind_exit, 18);
    t('{8'hcb}, isa_decode_pkg::kind_exit, 22);
    t('{8'hca, 8'h04, 8'h00}, isa_decode_pkg::kind_exit, 25);
    t('{8'heb, 8'h10}, isa_decode_pkg::kind_jmp, 14);
    t('{8'h62, 8'h07}, isa_decode_pkg::kind_bound, 33);
    foreach (fo[i]) t('{8'hf8 | 8'(i % 2)}, isa_decode_pkg::kind_carry, 2);
    t('{8'hf5}, isa_decode_pkg::kind_carry, 2);
    t('{8'hf0, 8'hf5}, isa_decode_pkg::kind_carry, 4);
    chk("lock", 32'h1, 32'(m.got.lock));
    t('{8'hd9, 8'he8}, isa_decode_pkg::kind_esc, 6);
    chk("esc_op", 32'h0d, 32'(m.got.esc_op));
    for (int i = 0; i < 80; i++) begin
      m.slow = i[2];
      f = 5'($urandom);
      cx = ($urandom % 4 == 0) ? 16'h1 : 16'($urandom % 12);
      setfc(f, cx);
      if ($urandom % 2) begin
        o = ($urandom % 2) ? {4'h7, 4'($urandom)} : fo[$urandom % 5];
        if (o == 8'hce)
          issue('{o});
        else
          issue('{o, 8'($urandom) & 8'h7f});
        chk("clocks", 32'(fcost(o, f, cx)), 32'(m.got.clocks));
        if (o[7:4] == 4'h7) chk("taken", 32'(jt(o[3:0], f)), 32'(m.got.taken));
      end else begin
        o = {ro[$urandom % 5], 1'($urandom)};
        p = 8'hf2 | 8'($urandom % 2);
        issue('{p, o});
        chk("clocks", 32'(rcost(o[7:1], int'(cx))), 32'(m.got.clocks));
        chk("rep", 32'h1, 32'(m.got.rep));
        chk("rep_z", 32'(p[0]), 32'(m.got.rep_z));
        chk("word", 32'(o[0]), 32'(m.got.word));
      end
    end
    end_of_test();
  end
endmodule
